// ### eil_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
// 80 ns bit time; scl stands high between frames
module eil_bus_master (
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // also serves as repeated start: data released before scl rises
    task automatic start();
        #20 sda_m = 1'b1;
        #20 scl = 1'b1;
        #40 sda_m = 1'b0;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #20 sda_m = 1'b0;
        #20 scl = 1'b1;
        #40 sda_m = 1'b1;
        #40;
    endtask
    task automatic xfer(input logic b, output logic r);
        #20 sda_m = b;
        #20 scl = 1'b1;
        #20 r = sda_w;
        #20 scl = 1'b0;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r);
        end
        xfer(1'b1, r);
        ack = !r;
    endtask
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, d[i]);
        end
        xfer(last, r);
    endtask
    task automatic write_cmd(input logic [6:0] dev, input logic [7:0] hi, input logic [7:0] lo,
                             input logic [7:0] d[$], input logic fin,
                             output logic [2:0] hdr, output logic [7:0] n);
        logic a;
        n = 8'h0;
        start();
        put({dev, 1'b0}, hdr[2]);
        put(hi, hdr[1]);
        put(lo, hdr[0]);
        foreach (d[i]) begin
            put(d[i], a);
            n = n + {7'h0, a};
        end
        if (fin) stop();
    endtask
    task automatic read_cmd(input logic [6:0] dev, input logic [7:0] lo, input int cnt,
                            output logic [7:0] q[$]);
        logic a;
        logic [7:0] b;
        q = {};
        start();
        put({dev, 1'b0}, a);
        put(8'ha5, a);
        put(lo, a);
        start();
        put({dev, 1'b1}, a);
        for (int i = 0; i < cnt; i++) begin
            get(i == cnt - 1, b);
            q.push_back(b);
        end
        stop();
    endtask
endmodule
`default_nettype wire

// ### eil_defines.svh
// Notes on behaviour
// (R1) Separate 256-byte identification page, reached only by its own commands.
// (R2) Page write uses the page write sequence with type field 1011b.
// (R3) Write ignores upper address byte except lock select bit; low byte selects byte.
// (R4) Locked page: every write data byte gets no acknowledge; contents unchanged.
// (R5) Lock command: single byte write, type 1011b, lock select bit one.
// (R6) Lock command data byte needs bit 1 set; other bits ignored.
// (R7) Completed lock command makes the page read-only forever.
// (R8) Page read uses random read with type 1011b; low byte is start.
// (R9) Master stops reading before passing the 256-byte page end.
// (R10) Probe: one write data byte acknowledged if unlocked, not if locked.
// (R11) Start in mid-command abandons the command unexecuted.
// (R12) Master should send start then stop after a lock-status probe.
// (R13) Stop ending a probe returns the device to standby.
// (R14) Delivered contents read erased, every byte FFh.
// (R15) Power-on reset puts logic in standby, deselected, awaiting start.
// (R16) Before reset release the device ignores the bus, no acknowledge.
// (R17) Single-bit error in a stored byte corrected on every read.
// (R18) Address byte: type bits 7..4, chip-select bits 3..1 match straps, r/w bit 0.
// (R19) Read/write flag one selects read, zero selects write.
// (R20) Byte address sent as two bytes, high byte first.
// (R21) During programming cycle no request is acknowledged.
// (R22) Lock kept in nonvolatile storage; gates writes and probe acknowledge.
// (R23) Unlocked write or lock command starts programming cycle at stop.
`ifndef EIL_DEFINES_SVH
`define EIL_DEFINES_SVH

`define EIL_TYPE_ID       4'hb
`define EIL_TYPE_MSB      7
`define EIL_TYPE_LSB      4
`define EIL_CS_MSB        3
`define EIL_CS_LSB        1
`define EIL_RW_BIT        0
`define EIL_LOCK_ADDR_BIT 2
`define EIL_LOCK_DATA_BIT 1
`define EIL_BYTE_W        8
`define EIL_ECC_W         4
`define EIL_PAGE_BYTES    256
`define EIL_IDX_W         9
`define EIL_ECC_COLS      32'hcba97653
`define EIL_ERASED_BYTE   8'hff
`define EIL_LAST_BIT      4'h7
`define EIL_ACK_SLOT      4'h8
`define EIL_CLK_MHZ       250
`define EIL_TWR_MS        5
`define EIL_TWR_CYCLES    (`EIL_TWR_MS * 1000 * `EIL_CLK_MHZ)
`define EIL_PROG_W        21

`endif

// ### eil_ident_page.sv
`timescale 1ns/10ps
`default_nettype none
`include "eil_defines.svh"
module eil_ident_page #(
    parameter int unsigned TWR_CYCLES = `EIL_TWR_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic factory_erase_n,
    input  wire logic scl,
    input  wire logic sda_in,
    input  wire logic chip_select_bit_2,
    input  wire logic chip_select_bit_1,
    input  wire logic chip_select_bit_0,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      id_page_locked,
    output logic      prog_busy
);

    localparam int ROW_W = `EIL_ECC_W + `EIL_BYTE_W;
    localparam logic [`EIL_PROG_W-1:0] PROG_LAST = `EIL_PROG_W'(TWR_CYCLES - 1);

    eil_pkg::eil_state_t r;
    eil_pkg::eil_state_t n;
    eil_pkg::eil_bit_t   lk;

    // nonvolatile cells: data with check bits, plus the lock flag
    logic [ROW_W-1:0]          mem  [`EIL_PAGE_BYTES];
    logic                      lock_reg;
    // staging of a page write until its stop condition
    logic [`EIL_BYTE_W-1:0]    pbuf [`EIL_PAGE_BYTES];

    logic                      start_ev;
    logic                      stop_ev;
    logic                      fall_ev;
    logic                      bit_ev;
    logic                      active;
    logic [`EIL_BYTE_W-1:0]    byte_in;
    logic                      pb_we;
    logic                      mem_we;
    logic [`EIL_BYTE_W-1:0]    commit_addr;
    logic [`EIL_BYTE_W-1:0]    commit_data;
    logic [ROW_W-1:0]          mem_wdata;
    logic                      lock_set;

    // check code: xor of a distinct column per data bit
    function automatic logic [`EIL_ECC_W-1:0] ecc_code(input logic [`EIL_BYTE_W-1:0] d);
        logic [31:0]            cols;
        logic [`EIL_ECC_W-1:0] c;
        cols = `EIL_ECC_COLS;
        c    = '0;
        for (int i = 0; i < `EIL_BYTE_W; i++) begin
            if (d[i]) begin
                c = c ^ cols[`EIL_ECC_W*i +: `EIL_ECC_W];
            end
        end
        return c;
    endfunction

    // syndrome matching a column flips that data bit; a syndrome with one bit
    // set is a check-bit error and leaves the data alone
    function automatic logic [`EIL_BYTE_W-1:0] ecc_fix(input logic [ROW_W-1:0] row);
        logic [31:0]              cols;
        logic [`EIL_ECC_W-1:0]    s;
        logic [`EIL_BYTE_W-1:0]   d;
        cols = `EIL_ECC_COLS;
        d    = row[`EIL_BYTE_W-1:0];
        s    = ecc_code(d) ^ row[ROW_W-1:`EIL_BYTE_W];
        for (int i = 0; i < `EIL_BYTE_W; i++) begin
            if (s == cols[`EIL_ECC_W*i +: `EIL_ECC_W]) begin
                d[i] = ~d[i];
            end
        end
        return d;
    endfunction

    eil_link_capture u_link (
        .scl     (scl),
        .resetn  (resetn),
        .sda_in  (sda_in),
        .bit_out (lk)
    );

    // start and stop need sda edges while scl is high, so they are seen here
    // on ref_clk from synchronised copies, never from the link domain
    assign start_ev = r.scl.s2 & r.scl.s3 & r.sda.s3 & ~r.sda.s2;
    assign stop_ev  = r.scl.s2 & r.scl.s3 & ~r.sda.s3 & r.sda.s2;
    assign fall_ev  = r.scl.s3 & ~r.scl.s2;
    assign bit_ev   = r.tog.s2 ^ r.tog.s3;
    assign byte_in  = {r.sh[`EIL_BYTE_W-2:0], lk.val};
    assign active   = (r.phase == eil_pkg::EIL_DEV) || (r.phase == eil_pkg::EIL_AHI) ||
                      (r.phase == eil_pkg::EIL_ALO) || (r.phase == eil_pkg::EIL_WR)  ||
                      (r.phase == eil_pkg::EIL_RD);

    assign commit_addr = r.commit_idx[`EIL_BYTE_W-1:0];
    assign commit_data = pbuf[commit_addr];
    assign mem_wdata   = {ecc_code(commit_data), commit_data};

    always_comb begin
        n          = r;
        pb_we      = 1'b0;
        mem_we     = 1'b0;
        lock_set   = 1'b0;

        n.scl.s1   = scl;
        n.scl.s2   = r.scl.s1;
        n.scl.s3   = r.scl.s2;
        n.sda.s1   = sda_in;
        n.sda.s2   = r.sda.s1;
        n.sda.s3   = r.sda.s2;
        n.tog.s1   = lk.tog;
        n.tog.s2   = r.tog.s1;
        n.tog.s3   = r.tog.s2;
        n.cs_s1    = {chip_select_bit_2, chip_select_bit_1, chip_select_bit_0};
        n.cs_s2    = r.cs_s1;

        if (r.phase == eil_pkg::EIL_PROG) begin
            // bus is ignored entirely while programming
            if (!r.commit_idx[`EIL_IDX_W-1]) begin
                mem_we       = r.wval[commit_addr]; // R23
                n.commit_idx = r.commit_idx + `EIL_IDX_W'(1);
            end
            n.prog_cnt = r.prog_cnt + `EIL_PROG_W'(1);
            n.oe       = 1'b0; // R21
            if (r.prog_cnt == PROG_LAST) begin
                lock_set    = r.pend_lock; // R7
                n.phase     = eil_pkg::EIL_IDLE;
                n.wval      = '0;
                n.pend_lock = 1'b0;
            end
        end else if (start_ev) begin
            // staged bytes and a pending lock are dropped here
            n.phase     = eil_pkg::EIL_DEV; // R11
            n.cnt       = '0;
            n.wval      = '0; // R11
            n.pend_lock = 1'b0;
            n.lock_sel  = 1'b0;
            n.ack_pend  = 1'b0;
            n.oe        = 1'b0;
        end else if (stop_ev) begin
            n.oe       = 1'b0;
            n.ack_pend = 1'b0;
            n.cnt      = '0;
            if ((r.phase == eil_pkg::EIL_WR) && ((|r.wval) || r.pend_lock)) begin
                n.phase      = eil_pkg::EIL_PROG; // R23
                n.prog_cnt   = '0;
                n.commit_idx = '0;
            end else begin
                n.phase = eil_pkg::EIL_IDLE; // R13
            end
        end else begin
            if (fall_ev) begin
                if (r.cnt == `EIL_ACK_SLOT) begin
                    n.oe = r.ack_pend;
                end else if (r.phase == eil_pkg::EIL_RD) begin
                    n.oe = ~r.tx[`EIL_BYTE_W-1];
                end else begin
                    n.oe = 1'b0;
                end
            end

            if (bit_ev && active) begin
                if (r.cnt != `EIL_ACK_SLOT) begin
                    n.sh  = byte_in;
                    n.cnt = r.cnt + 4'h1;
                    if (r.phase == eil_pkg::EIL_RD) begin
                        n.tx = {r.tx[`EIL_BYTE_W-2:0], 1'b0};
                    end
                    if (r.cnt == `EIL_LAST_BIT) begin
                        n.ack_pend = 1'b0;
                        n.nxt      = eil_pkg::EIL_IGN;
                        case (r.phase)
                            eil_pkg::EIL_DEV: begin
                                if ((byte_in[`EIL_TYPE_MSB:`EIL_TYPE_LSB] == `EIL_TYPE_ID) &&
                                    (byte_in[`EIL_CS_MSB:`EIL_CS_LSB] == r.cs_s2)) begin // R18
                                    n.ack_pend = 1'b1;
                                    if (byte_in[`EIL_RW_BIT]) begin
                                        n.nxt = eil_pkg::EIL_RD; // R19
                                    end else begin
                                        n.nxt = eil_pkg::EIL_AHI; // R2
                                    end
                                end
                            end
                            eil_pkg::EIL_AHI: begin
                                // only the lock select bit of the high byte counts
                                n.ack_pend = 1'b1;
                                n.lock_sel = byte_in[`EIL_LOCK_ADDR_BIT]; // R3
                                n.nxt      = eil_pkg::EIL_ALO; // R20
                            end
                            eil_pkg::EIL_ALO: begin
                                n.ack_pend = 1'b1;
                                n.ptr      = byte_in; // R8
                                n.nxt      = eil_pkg::EIL_WR;
                            end
                            eil_pkg::EIL_WR: begin
                                n.ack_pend = ~lock_reg; // R4
                                n.nxt      = eil_pkg::EIL_WR;
                                if (!lock_reg) begin
                                    if (r.lock_sel) begin // R5
                                        if (byte_in[`EIL_LOCK_DATA_BIT]) begin
                                            n.pend_lock = 1'b1; // R6
                                        end
                                    end else begin
                                        // page pointer wraps inside the page
                                        pb_we          = 1'b1; // R1
                                        n.wval[r.ptr]  = 1'b1;
                                        n.ptr          = r.ptr + 8'h01;
                                    end
                                end
                            end
                            eil_pkg::EIL_RD: begin
                                n.nxt = eil_pkg::EIL_RD;
                            end
                            default: begin
                                n.nxt = eil_pkg::EIL_IGN;
                            end
                        endcase
                    end
                end else begin
                    n.cnt      = '0;
                    n.ack_pend = 1'b0;
                    if (r.phase == eil_pkg::EIL_RD) begin
                        // master nack ends the read; stop or start follows
                        if (lk.val) begin
                            n.phase = eil_pkg::EIL_IGN;
                        end else begin
                            n.tx  = ecc_fix(mem[r.ptr]); // R17
                            n.ptr = r.ptr + 8'h01;
                        end
                    end else begin
                        n.phase = r.nxt;
                        if (r.nxt == eil_pkg::EIL_RD) begin
                            n.tx  = ecc_fix(mem[r.ptr]); // R17
                            n.ptr = r.ptr + 8'h01;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            r       <= '0; // R15 R16
            r.phase <= eil_pkg::EIL_IDLE;
            r.nxt   <= eil_pkg::EIL_IDLE;
        end else begin
            r <= n;
        end
    end

    // staging needs no reset: wval says which entries mean anything
    always_ff @(posedge ref_clk) begin
        if (pb_we) begin
            pbuf[r.ptr] <= byte_in;
        end
    end

    // erase brings the cells to the delivered state; power-on reset leaves them
    always_ff @(posedge ref_clk or negedge factory_erase_n) begin
        if (!factory_erase_n) begin
            for (int i = 0; i < `EIL_PAGE_BYTES; i++) begin
                mem[i] <= {ecc_code(`EIL_ERASED_BYTE), `EIL_ERASED_BYTE}; // R14
            end
        end else if (mem_we) begin
            mem[commit_addr] <= mem_wdata; // R17
        end
    end

    // lock flag has no clear path but erase, so it survives power cycles
    always_ff @(posedge ref_clk or negedge factory_erase_n) begin
        if (!factory_erase_n) begin
            lock_reg <= 1'b0;
        end else if (lock_set) begin
            lock_reg <= 1'b1; // R22 R7
        end
    end

    assign sda_out        = 1'b0;
    assign sda_oe         = r.oe; // R10
    assign id_page_locked = lock_reg;
    assign prog_busy      = (r.phase == eil_pkg::EIL_PROG);

endmodule
`default_nettype wire

// ### eil_ident_page_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module eil_ident_page_chk #(
    parameter int unsigned TWR_CYCLES = 400
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic factory_erase_n,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic chip_select_bit_2,
    input wire logic chip_select_bit_1,
    input wire logic chip_select_bit_0,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic id_page_locked,
    input wire logic prog_busy
);
    logic [31:0] busy_len_reg;
    // cycle count of the current busy stretch, too long for a repetition
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_len_reg <= 32'h0;
        end else begin
            busy_len_reg <= prog_busy ? busy_len_reg + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    property p_quiet_after_reset; $rose(resetn) |-> !sda_oe [*3]; endproperty
    property p_busy_silent; prog_busy |-> !sda_oe; endproperty
    property p_lock_sticky; id_page_locked && factory_erase_n |=> id_page_locked; endproperty
    property p_lock_at_prog; $rose(id_page_locked) |-> $past(prog_busy); endproperty
    property p_busy_len;
        $fell(prog_busy) |-> busy_len_reg >= TWR_CYCLES && busy_len_reg <= TWR_CYCLES + 1;
    endproperty
    property p_busy_from_stop; $rose(prog_busy) |-> scl && sda_in; endproperty
    property p_ack_after_fall; $rose(sda_oe) |-> !scl && $past(scl, 5); endproperty
    property p_oe_scl_low; $changed(sda_oe) |-> !scl; endproperty
    a_quiet_after_reset: assert property (p_quiet_after_reset)
        else $error("sda driven right after reset");
    a_busy_silent: assert property (p_busy_silent)
        else $error("acknowledge during programming");
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock cleared");
    a_lock_at_prog: assert property (p_lock_at_prog)
        else $error("lock set outside programming");
    a_busy_len: assert property (p_busy_len)
        else $error("programming length wrong");
    a_busy_from_stop: assert property (p_busy_from_stop)
        else $error("programming started without stop");
    a_ack_after_fall: assert property (p_ack_after_fall)
        else $error("sda driven outside scl low");
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("sda enable moved while scl high");
    c_prog: cover property ($rose(prog_busy));
    c_lock: cover property ($rose(id_page_locked));
    c_ack: cover property ($rose(sda_oe));
endmodule
bind eil_ident_page eil_ident_page_chk #(.TWR_CYCLES(TWR_CYCLES)) chk_u (
    .ref_clk(ref_clk), .resetn(resetn), .factory_erase_n(factory_erase_n), .scl(scl),
    .sda_in(sda_in), .chip_select_bit_2(chip_select_bit_2),
    .chip_select_bit_1(chip_select_bit_1), .chip_select_bit_0(chip_select_bit_0),
    .sda_out(sda_out), .sda_oe(sda_oe), .id_page_locked(id_page_locked),
    .prog_busy(prog_busy)
);
`default_nettype wire

// ### eil_ident_page_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module eil_ident_page_tb_top;
    localparam int unsigned TWR = 400;
    localparam int unsigned CEIL = 60000;
    localparam logic [6:0] DEV = {4'hb, 3'h5};
    typedef struct packed {logic [7:0] hi; logic [7:0] lo; logic [7:0] d;} eil_row_t;
    logic ref_clk, resetn, erase_n, sda_w, scl, sda_m, sda_out, sda_oe, locked, busy;
    int fail_count, checked, cycles;
    assign sda_w = sda_m & !(sda_oe & !sda_out);
    eil_ident_page #(.TWR_CYCLES(TWR)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .factory_erase_n(erase_n), .scl(scl),
        .sda_in(sda_w), .chip_select_bit_2(1'b1), .chip_select_bit_1(1'b0),
        .chip_select_bit_0(1'b1), .sda_out(sda_out), .sda_oe(sda_oe),
        .id_page_locked(locked), .prog_busy(busy)
    );
    eil_bus_master master_u (.sda_w(sda_w), .scl(scl), .sda_m(sda_m));
    always #2 ref_clk = ~ref_clk;
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == CEIL) begin
            fail_count++;
            summarize();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        for (int i = 0; i < TWR + 50 && busy !== 1'b0; i++) begin
            @(negedge ref_clk);
        end
    endtask
    eil_row_t rows [3] = '{'{8'h00, 8'h00, 8'h5a}, '{8'hfb, 8'hff, 8'ha5},
                           '{8'h00, 8'h80, 8'h3c}};
    initial begin
        logic [2:0] hdr;
        logic [7:0] n;
        logic [7:0] q[$];
        logic a;
        ref_clk = 1'b0;
        resetn = 1'b0;
        erase_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        resetn = 1'b1;
        erase_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        master_u.read_cmd(DEV, 8'hfc, 4, q);
        foreach (q[i]) check(q[i], 8'hff);
        check(q.size(), 8'h04);
        $display("erased read done");
        foreach (rows[i]) begin
            master_u.write_cmd(DEV, rows[i].hi, rows[i].lo, '{rows[i].d}, 1'b1, hdr, n);
            check({5'h0, hdr}, 8'h07);
            check(n, 8'h01);
            check({7'h0, busy}, 8'h01);
            settle();
            master_u.read_cmd(DEV, rows[i].lo, 1, q);
            check(q[0], rows[i].d);
            $display("row %0d done", i);
        end
        master_u.write_cmd({4'ha, 3'h5}, 8'h00, 8'h01, '{8'h00}, 1'b1, hdr, n);
        check({5'h0, hdr}, 8'h00);
        master_u.write_cmd({4'hb, 3'h4}, 8'h00, 8'h01, '{8'h00}, 1'b1, hdr, n);
        check({5'h0, hdr}, 8'h00);
        $display("address refusal done");
        master_u.write_cmd(DEV, 8'h00, 8'h40, '{8'h11, 8'h22, 8'h33}, 1'b1, hdr, n);
        check(n, 8'h03);
        master_u.start();
        master_u.put({DEV, 1'b0}, a);
        master_u.stop();
        check({7'h0, a}, 8'h00);
        settle();
        master_u.read_cmd(DEV, 8'h40, 3, q);
        check(q[0], 8'h11);
        check(q[1], 8'h22);
        check(q[2], 8'h33);
        $display("multi byte done");
        master_u.write_cmd(DEV, 8'h00, 8'h50, '{8'h77}, 1'b0, hdr, n);
        check(n, 8'h01);
        master_u.start();
        master_u.stop();
        check({7'h0, busy}, 8'h00);
        master_u.read_cmd(DEV, 8'h50, 1, q);
        check(q[0], 8'hff);
        $display("unlocked probe done");
        master_u.write_cmd(DEV, 8'h04, 8'h00, '{8'hfd}, 1'b1, hdr, n);
        check(n, 8'h01);
        settle();
        check({7'h0, locked}, 8'h00);
        master_u.write_cmd(DEV, 8'hfc, 8'h5a, '{8'hfe}, 1'b1, hdr, n);
        check(n, 8'h01);
        settle();
        check({7'h0, locked}, 8'h01);
        master_u.write_cmd(DEV, 8'h00, 8'h00, '{8'h33, 8'h44}, 1'b1, hdr, n);
        check(n, 8'h00);
        check({7'h0, busy}, 8'h00);
        master_u.read_cmd(DEV, 8'h00, 1, q);
        check(q[0], 8'h5a);
        master_u.write_cmd(DEV, 8'h00, 8'h10, '{8'h01}, 1'b0, hdr, n);
        check(n, 8'h00);
        master_u.start();
        master_u.stop();
        master_u.write_cmd(DEV, 8'h04, 8'h00, '{8'h02}, 1'b1, hdr, n);
        check(n, 8'h00);
        $display("locked page done");
        @(negedge ref_clk);
        resetn = 1'b0;
        master_u.start();
        master_u.put({DEV, 1'b0}, a);
        master_u.stop();
        check({7'h0, a}, 8'h00);
        @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        check({7'h0, locked}, 8'h01);
        master_u.read_cmd(DEV, 8'h80, 1, q);
        check(q[0], 8'h3c);
        $display("second reset done");
        summarize();
    end
endmodule
`default_nettype wire

// ### eil_link_capture.sv
`timescale 1ns/10ps
`default_nettype none
`include "eil_defines.svh"
// samples sda on each rising scl edge and flips a toggle; the value is held
// until the next rising edge, long after the toggle has crossed over
module eil_link_capture (
    input  wire logic       scl,
    input  wire logic       resetn,
    input  wire logic       sda_in,
    output eil_pkg::eil_bit_t bit_out
);

    eil_pkg::eil_bit_t link_reg;
    eil_pkg::eil_bit_t link_next;

    always_comb begin
        link_next     = link_reg;
        link_next.val = sda_in;
        link_next.tog = ~link_reg.tog;
    end

    always_ff @(posedge scl or negedge resetn) begin
        if (!resetn) begin
            link_reg <= '0;
        end else begin
            link_reg <= link_next;
        end
    end

    assign bit_out = link_reg;

endmodule
`default_nettype wire

// ### eil_pkg.sv
`default_nettype none
`include "eil_defines.svh"
package eil_pkg;

    typedef enum logic [3:0] {
        EIL_IDLE = 4'b0000,
        EIL_DEV  = 4'b0001,
        EIL_AHI  = 4'b0010,
        EIL_ALO  = 4'b0011,
        EIL_WR   = 4'b0100,
        EIL_RD   = 4'b0101,
        EIL_IGN  = 4'b0110,
        EIL_PROG = 4'b0111
    } eil_phase_t;

    typedef struct packed {
        logic tog;
        logic val;
    } eil_bit_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } eil_sync_t;

    typedef struct packed {
        eil_phase_t                  phase;
        eil_phase_t                  nxt;
        eil_sync_t                   scl;
        eil_sync_t                   sda;
        eil_sync_t                   tog;
        logic [2:0]                  cs_s1;
        logic [2:0]                  cs_s2;
        logic [3:0]                  cnt;
        logic [`EIL_BYTE_W-1:0]      sh;
        logic [`EIL_BYTE_W-1:0]      tx;
        logic [`EIL_BYTE_W-1:0]      ptr;
        logic                        ack_pend;
        logic                        oe;
        logic                        lock_sel;
        logic                        pend_lock;
        logic [`EIL_PAGE_BYTES-1:0]  wval;
        logic [`EIL_PROG_W-1:0]      prog_cnt;
        logic [`EIL_IDX_W-1:0]       commit_idx;
    } eil_state_t;

endpackage
`default_nettype wire
